// File: shared/wcc_pkg.sv
`default_nettype none
package wcc_pkg;
  // Clock and timing figures
  localparam int unsigned CLK_PERIOD_PS   = 10000;
  localparam int unsigned ERR_LATENCY_NS  = 13;
  localparam int unsigned ERR_LATENCY_CYC = ((ERR_LATENCY_NS * 1000) / CLK_PERIOD_PS < 1) ? 1 :
                                            (ERR_LATENCY_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned ERR_PIPE_CYC    = 1;
  localparam int unsigned PULSE_MIN_CYC   = 6;
  localparam int unsigned PULSE_MAX_CYC   = 10;
  localparam int unsigned PULSE_CYC       = 8;
  // Frame layout
  localparam int unsigned FRAME_UI   = 10;
  localparam int unsigned DATA_BEATS = 8;
  localparam int unsigned CHOP_BEATS = 4;
  localparam int unsigned DQ_W       = 8;
  localparam int unsigned LANES      = 9;
  localparam int unsigned X4_LANES   = 4;
  localparam int unsigned TREE_W     = 72;
  localparam int unsigned CRC_W      = 8;
  localparam logic [3:0]  LAST_UI    = 4'h9;
  localparam logic [3:0]  CRC_UI_LO  = 4'h8;
  localparam logic [7:0]  CRC_POLY   = 8'h07;
  localparam logic [7:0]  CRC_INIT   = 8'h00;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_MODE5    = 8'h04;
  localparam logic [7:0] ADDR_STAT     = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h14;
  // Field positions
  localparam int unsigned CTRL_CRC_EN  = 0;
  localparam int unsigned CTRL_OTF     = 1;
  localparam int unsigned CTRL_CHOP    = 2;
  localparam int unsigned CTRL_X8      = 3;
  localparam int unsigned CTRL_MASK_EN = 4;
  localparam int unsigned CTRL_W       = 5;
  localparam int unsigned MODE5_CLR    = 3;
  localparam int unsigned IRQ_CRC      = 0;
  localparam int unsigned IRQ_FRAME    = 1;
  localparam int unsigned IRQ_PARITY   = 2;
  localparam int unsigned IRQ_W        = 3;
  // Reset values
  localparam logic [4:0] CTRL_RST   = 5'h00;
  localparam logic [2:0] IRQ_EN_RST = 3'h0;
  typedef enum logic {WCC_IDLE, WCC_DATA} wcc_frame_state_t;
endpackage
`default_nettype wire

// File: shared/wcc_alert_if.sv
`timescale 1ns/10ps
`default_nettype none
interface wcc_alert_if;
  logic fire;
  logic active;
  modport src (output fire, input active);
  modport dst (input fire, output active);
endinterface
`default_nettype wire

// File: hw/wcc_crc8.sv
`timescale 1ns/10ps
`default_nettype none
module wcc_crc8 (
  input  wire logic [wcc_pkg::TREE_W-1:0] data_i,
  output logic      [wcc_pkg::CRC_W-1:0]  crc_o
);
  // Serial form of the eight-bit tree, top bit first; synthesis flattens it
  function automatic logic [7:0] crc_calc(input logic [wcc_pkg::TREE_W-1:0] d);
    logic [7:0] c;
    logic       fb;
    c = wcc_pkg::CRC_INIT;
    for (int i = wcc_pkg::TREE_W - 1; i >= 0; i--) begin
      fb = c[7] ^ d[i];
      c  = {c[6:0], 1'b0} ^ (fb ? wcc_pkg::CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  assign crc_o = crc_calc(data_i);
endmodule
`default_nettype wire

// File: hw/wcc_alert_pulse.sv
`timescale 1ns/10ps
`default_nettype none
module wcc_alert_pulse #(
  parameter int unsigned PULSE_CYC = wcc_pkg::PULSE_CYC
) (
  input  wire logic  hclk,
  input  wire logic  hresetn,
  wcc_alert_if.dst   err,
  output logic       alert_n_o,
  output logic       alert_n_oe
);
  if (PULSE_CYC < wcc_pkg::PULSE_MIN_CYC || PULSE_CYC > wcc_pkg::PULSE_MAX_CYC) begin : g_bad
    $error("pulse width out of range");
  end
  if (wcc_pkg::ERR_PIPE_CYC > wcc_pkg::ERR_LATENCY_CYC) begin : g_slow
    $error("error path slower than allowed");
  end

  logic [3:0] cnt_q;
  logic [3:0] cnt_d;

  // A fire during a pulse merges into it, so width never exceeds the maximum
  assign cnt_d = (cnt_q != 4'h0) ? cnt_q - 4'h1 :
                 err.fire ? 4'(PULSE_CYC) : 4'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Open drain: only ever pulls low, one edge after the fire
  assign alert_n_o  = 1'b0;
  assign alert_n_oe = (cnt_q != 4'h0);
  assign err.active = alert_n_oe;
endmodule
`default_nettype wire

// File: hw/wcc_write_crc_chk.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Error line goes low within 13 ns of a detected mismatch.
// - Error pulse is held low between 6 and 10 clocks.
// - Chopped four-beat writes are CRC checked as well as full bursts.
// - CRC check runs only on frames whose command arrives while the enable bit is set.
// - Every checked frame is ten UI long, chopped or full.
// - Chop per command is honoured when on-the-fly mode is set.
// - Four-bit device in chop mode: 16 real bits, other inputs are one.
// - Half select high: bits 7:4 of each data lane feed tree inputs 3:0.
// - Eight-bit device in chop mode: 36 tree bits, data-lane beats 4-7 are ones.
// - Half select low: inputs 67:64 take mask lane or ones if off.
// - Half select high: inputs 71:68 take mask lane or ones if off.
// - Computed checksum is compared with received one; mismatch is reported.
// - Errors show as a pulse on the shared error line and in the sticky interrupt status.
// - Mismatch sets mode five clear bit and status page bit until cleared.
// - A sixteen-bit part would use two such trees, one per byte.
module wcc_write_crc_chk #(
  parameter int unsigned PULSE_CYC = wcc_pkg::PULSE_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        link_clk,
  input  wire logic        wr_cmd,
  input  wire logic        cmd_chop,
  input  wire logic        burst_half_select,
  input  wire logic [7:0]  dq,
  input  wire logic        mask_lane_n,
  input  wire logic        ca_parity_err,
  output logic             alert_n_o,
  output logic             alert_n_oe,
  output logic             irq
);
  localparam int unsigned PIN_W = 14;

  wcc_alert_if alert_bus ();

  // Pin synchronisers
  logic [PIN_W-1:0] pin_s1_q;
  logic [PIN_W-1:0] pin_s2_q;
  logic             link_clk_s3_q;
  logic             parity_s3_q;
  logic [PIN_W-1:0] pin_raw;

  assign pin_raw = {ca_parity_err, mask_lane_n, dq, burst_half_select, cmd_chop, wr_cmd,
                    link_clk};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Edge history, read only from the second stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_clk_s3_q <= 1'b0;
      parity_s3_q   <= 1'b0;
    end else begin
      link_clk_s3_q <= pin_s2_q[0];
      parity_s3_q   <= pin_s2_q[13];
    end
  end

  logic       link_clk_s;
  logic       cmd_s;
  logic       chop_s;
  logic       half_s;
  logic [7:0] dq_s;
  logic       mask_s;
  logic       parity_s;
  logic       link_rise;
  logic       parity_rise;

  assign link_clk_s  = pin_s2_q[0];
  assign cmd_s       = pin_s2_q[1];
  assign chop_s      = pin_s2_q[2];
  assign half_s      = pin_s2_q[3];
  assign dq_s        = pin_s2_q[11:4];
  assign mask_s      = pin_s2_q[12];
  assign parity_s    = pin_s2_q[13];
  assign link_rise   = link_clk_s & ~link_clk_s3_q;
  assign parity_rise = parity_s & ~parity_s3_q;

  // Control register fields
  logic [wcc_pkg::CTRL_W-1:0] ctrl_q;
  logic                       crc_en;
  logic                       otf_en;
  logic                       chop_fixed;
  logic                       is_x8;
  logic                       mask_en;

  assign crc_en     = ctrl_q[wcc_pkg::CTRL_CRC_EN];
  assign otf_en     = ctrl_q[wcc_pkg::CTRL_OTF];
  assign chop_fixed = ctrl_q[wcc_pkg::CTRL_CHOP];
  assign is_x8      = ctrl_q[wcc_pkg::CTRL_X8];
  assign mask_en    = ctrl_q[wcc_pkg::CTRL_MASK_EN];

  // Frame capture: command on one link edge, then ten UI on the following ones
  wcc_pkg::wcc_frame_state_t state_q;
  logic [3:0]                ui_q;
  logic                      chop_q;
  logic                      half_q;
  logic                      last_ui;
  logic                      start;
  logic                      chop_sel;

  assign last_ui  = (ui_q == wcc_pkg::LAST_UI);
  assign start    = link_rise & (state_q == wcc_pkg::WCC_IDLE) & cmd_s & crc_en;
  assign chop_sel = otf_en ? chop_s : chop_fixed;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= wcc_pkg::WCC_IDLE;
      ui_q    <= 4'h0;
      chop_q  <= 1'b0;
      half_q  <= 1'b0;
    end else if (link_rise) begin
      case (state_q)
        wcc_pkg::WCC_IDLE: begin
          if (start) begin
            state_q <= wcc_pkg::WCC_DATA;
            ui_q    <= 4'h0;
            chop_q  <= chop_sel;
            half_q  <= half_s;
          end
        end
        wcc_pkg::WCC_DATA: begin
          if (last_ui) begin
            state_q <= wcc_pkg::WCC_IDLE;
          end
          ui_q <= ui_q + 4'h1;
        end
        default: begin
          state_q <= wcc_pkg::WCC_IDLE;
        end
      endcase
    end
  end

  // Received beats, one word of all nine lanes per UI
  logic [wcc_pkg::LANES-1:0] beat_q [wcc_pkg::FRAME_UI];
  logic                      take_beat;

  assign take_beat = link_rise & (state_q == wcc_pkg::WCC_DATA);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < wcc_pkg::FRAME_UI; i++) begin
        beat_q[i] <= '0;
      end
    end else if (take_beat) begin
      beat_q[ui_q] <= {mask_s, dq_s};
    end
  end

  // Check strobe one cycle after the last UI lands
  logic check_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      check_q <= 1'b0;
    end else begin
      check_q <= take_beat & last_ui;
    end
  end

  // Tree input vector; the layout repeats per lane and per beat.
  // A sixteen-bit part would instantiate this vector twice, once per byte.
  logic [wcc_pkg::TREE_W-1:0] tree;
  logic                       mask_on;

  assign mask_on = is_x8 & mask_en;

  for (genvar l = 0; l < wcc_pkg::LANES; l++) begin : g_lane
    for (genvar b = 0; b < wcc_pkg::DATA_BEATS; b++) begin : g_beat
      if (l < wcc_pkg::DQ_W) begin : g_dq
        logic lane_off;
        assign lane_off = ~is_x8 & (l >= wcc_pkg::X4_LANES);
        // Under chop, received beats 0-3 always sit at inputs 3:0 of the lane,
        // whichever half was addressed; inputs 7:4 are ones.
        assign tree[l*8+b] = lane_off | (chop_q & (b >= wcc_pkg::CHOP_BEATS)) |
                             beat_q[b][l];
      end else if (b >= wcc_pkg::CHOP_BEATS) begin : g_mask_hi
        // Under chop, upper half takes the mask lane only for a high half select
        assign tree[l*8+b] = ~mask_on |
                             (chop_q ? ~half_q | beat_q[b-4][l] : beat_q[b][l]);
      end else begin : g_mask_lo
        // Under chop, lower half takes the mask lane only for a low half select
        assign tree[l*8+b] = ~mask_on |
                             (chop_q ? half_q | beat_q[b][l] : beat_q[b][l]);
      end
    end
  end

  // Received checksum: split over two beats for four lanes, one beat for eight
  logic [wcc_pkg::CRC_W-1:0] crc_rx;
  logic [wcc_pkg::CRC_W-1:0] crc_calc;
  logic                      mismatch;

  assign crc_rx = is_x8 ? beat_q[wcc_pkg::CRC_UI_LO][7:0] :
                  {beat_q[wcc_pkg::LAST_UI][3:0], beat_q[wcc_pkg::CRC_UI_LO][3:0]};

  wcc_crc8 u_crc (
    .data_i (tree),
    .crc_o  (crc_calc)
  );

  assign mismatch = check_q & (crc_calc != crc_rx);

  // Both error sources share the one pulse generator
  assign alert_bus.fire = mismatch | parity_rise;

  wcc_alert_pulse #(
    .PULSE_CYC (PULSE_CYC)
  ) u_alert (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .err        (alert_bus),
    .alert_n_o  (alert_n_o),
    .alert_n_oe (alert_n_oe)
  );

  // Bus address phase capture
  logic       take;
  logic [7:0] addr_q;
  logic       wr_q;
  logic       dph_q;

  assign take      = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= 8'h00;
      wr_q   <= 1'b0;
      dph_q  <= 1'b0;
    end else begin
      addr_q <= haddr[7:0];
      wr_q   <= hwrite;
      dph_q  <= take;
    end
  end

  // Write decode in the data phase; unmapped offsets are ignored
  logic wr_ctrl;
  logic wr_mode5;
  logic wr_irq_clr;
  logic wr_irq_en;

  assign wr_ctrl    = dph_q & wr_q & (addr_q == wcc_pkg::ADDR_CTRL);
  assign wr_mode5   = dph_q & wr_q & (addr_q == wcc_pkg::ADDR_MODE5);
  assign wr_irq_clr = dph_q & wr_q & (addr_q == wcc_pkg::ADDR_IRQ_CLR);
  assign wr_irq_en  = dph_q & wr_q & (addr_q == wcc_pkg::ADDR_IRQ_EN);

  // Error flags: a mismatch in the clearing cycle wins over the clear
  logic mode5_clr_q;
  logic status_page_q;
  logic soft_clear;

  assign soft_clear = wr_mode5 & ~hwdata[wcc_pkg::MODE5_CLR];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode5_clr_q   <= 1'b0;
      status_page_q <= 1'b0;
    end else begin
      mode5_clr_q   <= mismatch | (mode5_clr_q & ~soft_clear);
      status_page_q <= mismatch | (status_page_q & ~soft_clear);
    end
  end

  // Control, interrupt enable and last checksums
  logic [wcc_pkg::IRQ_W-1:0]  irq_en_q;
  logic [wcc_pkg::IRQ_W-1:0]  irq_stat_q;
  logic [wcc_pkg::IRQ_W-1:0]  irq_evt;
  logic [wcc_pkg::CRC_W-1:0]  last_calc_q;
  logic [wcc_pkg::CRC_W-1:0]  last_rx_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q   <= wcc_pkg::CTRL_RST;
      irq_en_q <= wcc_pkg::IRQ_EN_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= hwdata[wcc_pkg::CTRL_W-1:0];
      end
      if (wr_irq_en) begin
        irq_en_q <= hwdata[wcc_pkg::IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_calc_q <= 8'h00;
      last_rx_q   <= 8'h00;
    end else if (check_q) begin
      last_calc_q <= crc_calc;
      last_rx_q   <= crc_rx;
    end
  end

  // Sticky interrupt status; write one to clear, a new event wins
  assign irq_evt = {parity_rise, check_q, mismatch};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= irq_evt | (irq_stat_q & ~(wr_irq_clr ? hwdata[2:0] : 3'h0));
    end
  end

  assign irq = |(irq_stat_q & irq_en_q);

  // Read mux, sampled in the address phase so data is a flop in the data phase.
  // Limitation: a read right behind a write to the same word sees the old value.
  logic [31:0] rd_mux;
  logic [31:0] stat_word;
  logic [31:0] hrdata_q;

  assign stat_word = {8'h00, last_rx_q, last_calc_q, 5'h00, alert_bus.active,
                      (state_q == wcc_pkg::WCC_DATA), status_page_q};
  assign rd_mux = (haddr[7:0] == wcc_pkg::ADDR_CTRL)     ? {27'h0, ctrl_q} :
                  (haddr[7:0] == wcc_pkg::ADDR_MODE5)    ? {28'h0, mode5_clr_q, 3'h0} :
                  (haddr[7:0] == wcc_pkg::ADDR_STAT)     ? stat_word :
                  (haddr[7:0] == wcc_pkg::ADDR_IRQ_STAT) ? {29'h0, irq_stat_q} :
                  (haddr[7:0] == wcc_pkg::ADDR_IRQ_EN)   ? {29'h0, irq_en_q} : 32'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0;
    end else if (take & ~hwrite) begin
      hrdata_q <= rd_mux;
    end
  end

  assign hrdata = hrdata_q;
endmodule
`default_nettype wire

// File: testbench/wcc_chk_sva.sv
`timescale 1ns/10ps
`default_nettype none
// Watches the error line and the register bus at the top ports
module wcc_chk_sva #(
  parameter int unsigned PULSE_CYC = 8
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        ca_parity_err,
  input wire logic        alert_n_o,
  input wire logic        alert_n_oe
);
  logic [4:0] low_cnt_q;
  // Counts low cycles so the width is judged without a long repetition
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_cnt_q <= 5'h00;
    end else begin
      low_cnt_q <= alert_n_oe ? low_cnt_q + 5'h01 : 5'h00;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_drive_low: assert property (alert_n_oe |-> !alert_n_o)
    else $error("error line enabled but not low");
  a_pulse_hold: assert property ($rose(alert_n_oe) |=> alert_n_oe [*5])
    else $error("error pulse under six cycles");
  a_pulse_exact: assert property ($fell(alert_n_oe) |-> low_cnt_q == PULSE_CYC)
    else $error("error pulse width wrong");
  a_pulse_cap: assert property (alert_n_oe |-> low_cnt_q < 5'h0a)
    else $error("error pulse over ten cycles");
  a_parity_alert: assert property ($rose(ca_parity_err) && !alert_n_oe |-> ##[1:4] alert_n_oe)
    else $error("parity edge gave no pulse");
  a_unmapped_zero: assert property (hsel && htrans[1] && hready && !hwrite &&
                                    haddr[7:0] == 8'h18 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind wcc_write_crc_chk wcc_chk_sva #(.PULSE_CYC(PULSE_CYC)) chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .ca_parity_err(ca_parity_err), .alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe));
`default_nettype wire

// File: testbench/wcc_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
// Link-side sender; its clock runs only while a frame is on the wire
module wcc_ctrl_model (
  output logic       link_clk,
  output logic       wr_cmd,
  output logic       cmd_chop,
  output logic       burst_half_select,
  output logic [7:0] dq,
  output logic       mask_lane_n
);
  initial begin
    {link_clk, wr_cmd, cmd_chop, burst_half_select, mask_lane_n, dq} = 13'h01ff;
  end
  // Builds the tree, the checksum and the ten-beat frame, then clocks it out
  task automatic send_frame(input logic x8, input logic chop, input logic half,
      input logic mask_en, input logic [63:0] d, input logic [7:0] m, input logic bad,
      output logic [7:0] crc);
    logic [71:0] tree;
    logic [8:0]  ui [10];
    int          nb;
    nb = chop ? 4 : 8;
    tree = '1;
    for (int b = 0; b < 10; b++) ui[b] = 9'h1ff;
    for (int b = 0; b < nb; b++) begin
      for (int l = 0; l < (x8 ? 8 : 4); l++) begin
        tree[l*8+b] = d[l*8+b];
        ui[b][l] = d[l*8+b];
      end
      if (x8 && mask_en) begin
        tree[64+b+((chop && half) ? 4 : 0)] = m[b];
        ui[b][8] = m[b];
      end
    end
    crc = 8'h00;
    for (int i = 71; i >= 0; i--) crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ tree[i]) ? 8'h07 : 8'h00);
    ui[8][7:0] = x8 ? crc ^ {7'h0, bad} : {4'hf, crc[3:0] ^ {3'h0, bad}};
    if (!x8) ui[9][3:0] = crc[7:4];
    #3.7;
    {wr_cmd, cmd_chop, burst_half_select} = {1'b1, chop, half};
    // Pins change on the falling edge, well away from the sampling edge
    for (int e = 0; e < 11; e++) begin
      #62.5 link_clk = 1'b1;
      #62.5 link_clk = 1'b0;
      wr_cmd = 1'b0;
      {mask_lane_n, dq} = (e < 10) ? ui[e] : ~ui[9];
    end
  endtask
endmodule
`default_nettype wire

// File: testbench/write_crc_burst_chop_checker_bench.sv
`timescale 1ns/10ps
`default_nettype none
module write_crc_burst_chop_checker_bench;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, ca_parity_err;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        link_clk, wr_cmd, cmd_chop, burst_half_select, mask_lane_n;
  logic        alert_n_o, alert_n_oe, irq;
  logic [7:0]  dq, c;
  int          mismatches = 0;
  int          samples_checked = 0;
  assign hready = hreadyout;
  wcc_write_crc_chk dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link_clk(link_clk),
    .wr_cmd(wr_cmd), .cmd_chop(cmd_chop), .burst_half_select(burst_half_select), .dq(dq),
    .mask_lane_n(mask_lane_n), .ca_parity_err(ca_parity_err), .alert_n_o(alert_n_o),
    .alert_n_oe(alert_n_oe), .irq(irq));
  wcc_ctrl_model ctrl_u (.link_clk(link_clk), .wr_cmd(wr_cmd), .cmd_chop(cmd_chop),
    .burst_half_select(burst_half_select), .dq(dq), .mask_lane_n(mask_lane_n));
  // Clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // One single AHB transfer; waits on hready with a bound in both phases
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int n;
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, 24'h0, a, w};
    n = 0;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, wd};
    n = 0;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    r = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
      input string n);
    ahb(a, 1'b0, 32'h0);
    check(n, e, r & m);
  endtask
  // Sends one frame and judges the error line once it is over
  task automatic frame(input logic x8, input logic chop, input logic half, input logic mk,
      input logic bad, input logic ea, input logic [63:0] d);
    ctrl_u.send_frame(x8, chop, half, mk, d, 8'h96, bad, c);
    check("error line at frame end", {31'h0, ea}, {31'h0, alert_n_oe});
    repeat (12) @(posedge hclk);
    check("error line released", 32'h0, {31'h0, alert_n_oe});
  endtask
  task automatic t_regs();
    rd_chk(wcc_pkg::ADDR_CTRL, 32'hffffffff, 32'h0, "ctrl reset");
    rd_chk(wcc_pkg::ADDR_IRQ_EN, 32'hffffffff, 32'h0, "irq enable reset");
    ahb(8'h18, 1'b1, 32'hffffffff);
    rd_chk(8'h18, 32'hffffffff, 32'h0, "unmapped word");
    ahb(wcc_pkg::ADDR_CTRL, 1'b1, 32'h15);
    rd_chk(wcc_pkg::ADDR_CTRL, 32'hffffffff, 32'h15, "ctrl read back");
  endtask
  // Every width, half and mask-lane combination with a good checksum
  task automatic t_good(input logic otf);
    for (int k = 0; k < 8; k++) begin
      ahb(wcc_pkg::ADDR_CTRL, 1'b1, {27'h0, k[0], k[2], !otf, otf, 1'b1});
      ahb(wcc_pkg::ADDR_IRQ_CLR, 1'b1, 32'h7);
      frame(k[2], !otf || k[1], k[1], k[0], 1'b0, 1'b0, 64'h3c5a96e10ff0a55a ^ {8{k[7:0]}});
      rd_chk(wcc_pkg::ADDR_STAT, 32'h00ffff00, {8'h0, c, c, 8'h0}, "crc fields");
      rd_chk(wcc_pkg::ADDR_IRQ_STAT, 32'h7, 32'h2, "good frame status");
    end
  endtask
  task automatic t_bad();
    ahb(wcc_pkg::ADDR_CTRL, 1'b1, 32'h05);
    ahb(wcc_pkg::ADDR_IRQ_EN, 1'b1, 32'h1);
    frame(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 64'h0123456789abcdef);
    rd_chk(wcc_pkg::ADDR_IRQ_STAT, 32'h7, 32'h3, "mismatch status");
    rd_chk(wcc_pkg::ADDR_MODE5, 32'h8, 32'h8, "clear bit set");
    rd_chk(wcc_pkg::ADDR_STAT, 32'h1, 32'h1, "status page bit");
    check("irq raised", 32'h1, {31'h0, irq});
    ahb(wcc_pkg::ADDR_IRQ_EN, 1'b1, 32'h0);
    @(negedge hclk);
    check("irq masked", 32'h0, {31'h0, irq});
    ahb(wcc_pkg::ADDR_IRQ_EN, 1'b1, 32'h1);
    ahb(wcc_pkg::ADDR_IRQ_CLR, 1'b1, 32'h1);
    @(negedge hclk);
    check("irq cleared", 32'h0, {31'h0, irq});
    ahb(wcc_pkg::ADDR_MODE5, 1'b1, 32'h8);
    rd_chk(wcc_pkg::ADDR_MODE5, 32'h8, 32'h8, "clear bit kept");
    ahb(wcc_pkg::ADDR_MODE5, 1'b1, 32'h0);
    rd_chk(wcc_pkg::ADDR_MODE5, 32'h8, 32'h0, "clear bit cleared");
    rd_chk(wcc_pkg::ADDR_STAT, 32'h1, 32'h0, "status page cleared");
  endtask
  task automatic t_off_and_parity();
    ahb(wcc_pkg::ADDR_CTRL, 1'b1, 32'h04);
    ahb(wcc_pkg::ADDR_IRQ_CLR, 1'b1, 32'h7);
    frame(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 64'hfedcba9876543210);
    rd_chk(wcc_pkg::ADDR_IRQ_STAT, 32'h7, 32'h0, "disabled frame status");
    ahb(wcc_pkg::ADDR_IRQ_EN, 1'b1, 32'h4);
    ca_parity_err <= 1'b1;
    repeat (5) @(posedge hclk);
    check("parity pulse", 32'h1, {31'h0, alert_n_oe});
    check("parity irq", 32'h1, {31'h0, irq});
    ca_parity_err <= 1'b0;
    repeat (12) @(posedge hclk);
    rd_chk(wcc_pkg::ADDR_IRQ_STAT, 32'h7, 32'h4, "parity status");
    rd_chk(wcc_pkg::ADDR_MODE5, 32'h8, 32'h0, "parity leaves clear bit");
  endtask
  task automatic print_verdict();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    {hresetn, hsel, haddr, htrans, hwrite, hsize, hwdata, ca_parity_err} = {37'h0, 3'h2, 33'h0};
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    t_regs();
    t_good(1'b0);
    t_good(1'b1);
    t_bad();
    t_off_and_parity();
    print_verdict();
  end
  // Watchdog well beyond the expected run of about 30 us
  initial begin
    #300us;
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire
